// ### pkg/timer_ctrl_pkg.sv
// package: register map, field positions and types for the type-B timer control block
package timer_ctrl_pkg;
  localparam logic [11:0] ctrl_lo_addr = 12'h000;
  localparam logic [11:0] ctrl_hi_addr = 12'h004;
  localparam logic [11:0] count_lo_addr = 12'h008;
  localparam logic [11:0] count_hi_addr = 12'h00C;
  localparam logic [11:0] status_addr = 12'h010;
  localparam int on_bit = 15;
  localparam int idle_halt_bit = 13;
  localparam int gate_bit = 7;
  localparam int prescale_lsb = 4;
  localparam int pair_bit = 3;
  localparam int source_bit = 1;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] presc_reset = 8'h00;
  localparam int pclk_mhz = 20;

  typedef struct packed {
    logic on;
    logic idle_halt;
    logic gated_accumulate;
    logic [2:0] prescale_select;
    logic pair_wide_mode;
    logic clock_source_select;
  } ctrl_t;

  typedef struct packed {
    logic tick;
    logic gate;
  } count_src_t;
endpackage

// ### logic/type_b_timer_control.sv
// type-B timer pair (even and odd instance) with control registers, prescalers and counters
// Contract
// - bit 15 switches timer on or off
// - bit 13 halts timer during idle
// - external source: gate ignored, reads zero
// - internal source: gate bit enables accumulation
// - prescale 1,2,4,8,16,32,64,256 by field
// - pair bit exists on even timer only
// - in pair mode odd settings are ignored (here the odd idle bit still halts both halves in idle)
// - unused control bits read zero
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module type_b_timer_control
  import timer_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic ext_clk_lo,
  input wire logic ext_clk_hi,
  input wire logic gate_lo,
  input wire logic gate_hi,
  output logic run_lo,
  output logic run_hi
);

  // register file, one control word per timer; the pair bit only lives in the even one
  // counts are plain 16-bit halves; reading both words of a running pair is not atomic
  ctrl_t ctrl_lo;
  ctrl_t ctrl_hi;
  logic [15:0] count_lo;
  logic [15:0] count_hi;
  logic [7:0] presc_lo;
  logic [7:0] presc_hi;
  logic ext_prev_lo;
  logic ext_prev_hi;
  logic gate_prev_lo;
  logic gate_prev_hi;

  // prescale ratio minus one, for the field code
  // 1:128 has no code, so the ratio is not a plain power of the field value
  function automatic logic [7:0] presc_limit(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h00;
    unique case (sel)
      3'h0: r = 8'h00;
      3'h1: r = 8'h01;
      3'h2: r = 8'h03;
      3'h3: r = 8'h07;
      3'h4: r = 8'h0F;
      3'h5: r = 8'h1F;
      3'h6: r = 8'h3F;
      3'h7: r = 8'hFF; // 1:256 skips 1:128
    endcase
    return r;
  endfunction

  // readback image; unused positions stay zero and the gate bit hides under external source
  // the pair bit only reads back on the even word
  function automatic logic [31:0] ctrl_image(input ctrl_t c, input logic even);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[on_bit] = c.on;
    w[idle_halt_bit] = c.idle_halt;
    w[gate_bit] = c.gated_accumulate & ~c.clock_source_select;
    w[prescale_lsb +: 3] = c.prescale_select;
    w[pair_bit] = c.pair_wide_mode & even;
    w[source_bit] = c.clock_source_select;
    return w;
  endfunction

  // write decode; the odd word drops the pair bit so it can never be seen or act there
  function automatic ctrl_t ctrl_from(input logic [31:0] d, input logic even);
    ctrl_t c;
    c.on = d[on_bit];
    c.idle_halt = d[idle_halt_bit];
    c.gated_accumulate = d[gate_bit];
    c.prescale_select = d[prescale_lsb +: 3];
    c.pair_wide_mode = d[pair_bit] & even;
    c.clock_source_select = d[source_bit];
    return c;
  endfunction

  // apb decode: single wait-free access phase
  // writes act in the access cycle, reads are captured in the setup cycle
  wire logic wr_en = psel & penable & pwrite;
  wire logic rd_en = psel & ~penable & ~pwrite;
  wire logic hit_ctrl_lo = (paddr == ctrl_lo_addr);
  wire logic hit_ctrl_hi = (paddr == ctrl_hi_addr);
  wire logic hit_cnt_lo = (paddr == count_lo_addr);
  wire logic hit_cnt_hi = (paddr == count_hi_addr);
  wire logic hit_status = (paddr == status_addr);
  wire logic mapped = hit_ctrl_lo | hit_ctrl_hi | hit_cnt_lo | hit_cnt_hi | hit_status;

  // in pair mode the odd timer takes every setting from the even one
  // the one exception is the odd idle bit: software keeps it clear for the pair to
  // run in idle, and a set odd bit stops both halves together, so the carry chain
  // never sees a half-stopped 32-bit count
  wire logic pair = ctrl_lo.pair_wide_mode;
  wire ctrl_t eff_hi = pair ? ctrl_lo : ctrl_hi;
  // even half stops on its own bit, or on the odd bit while paired
  wire logic idle_stop_lo = idle_mode & (ctrl_lo.idle_halt | (pair & ctrl_hi.idle_halt));
  wire logic idle_stop_hi = idle_mode & (ctrl_hi.idle_halt | (pair & ctrl_lo.idle_halt));
  // run state: on and not idle-stopped; in pair mode the odd half follows the even
  wire logic active_lo = ctrl_lo.on & ~idle_stop_lo;
  wire logic active_hi = eff_hi.on & ~idle_stop_hi & ~(pair & idle_stop_lo);

  // input events: pclk cycle or rising edge of the external input
  // an edge needs one low sample then one high sample, so input pulses must span a pclk
  wire count_src_t src_lo = '{tick: ctrl_lo.clock_source_select ? (ext_clk_lo & ~ext_prev_lo) : 1'b1,
                              gate: gate_lo};
  wire count_src_t src_hi = '{tick: eff_hi.clock_source_select ? (ext_clk_hi & ~ext_prev_hi) : 1'b1,
                              gate: gate_hi};

  // gated mode only exists on the internal source
  wire logic gated_lo = ctrl_lo.gated_accumulate & ~ctrl_lo.clock_source_select;
  wire logic gated_hi = eff_hi.gated_accumulate & ~eff_hi.clock_source_select;
  // a tick is taken only while active, and in gated mode only with the gate high
  wire logic take_lo = active_lo & src_lo.tick & (~gated_lo | src_lo.gate);
  wire logic take_hi = active_hi & src_hi.tick & (~gated_hi | src_hi.gate);
  // prescaler terminal count per half
  wire logic presc_done_lo = (presc_lo == presc_limit(ctrl_lo.prescale_select));
  wire logic presc_done_hi = (presc_hi == presc_limit(eff_hi.prescale_select));
  // one count step per completed prescale cycle
  wire logic step_lo = take_lo & presc_done_lo;
  // paired: odd half counts on the even half's carry, no prescaler of its own
  // the carry comes from the step that wraps the even count, so both halves move on one edge
  wire logic step_hi = pair ? (step_lo & (count_lo == 16'hFFFF)) : (take_hi & presc_done_hi);

  // status view: live run state of both halves and the gate inputs one cycle late
  wire logic [31:0] status_word = {28'h0000000, gate_prev_hi, gate_prev_lo, active_hi, active_lo};
  // read mux; unmapped offsets read zero so a stray read is harmless
  wire logic [31:0] next_rdata = hit_ctrl_lo ? ctrl_image(ctrl_lo, 1'b1) :
                                 hit_ctrl_hi ? ctrl_image(ctrl_hi, 1'b0) :
                                 hit_cnt_lo ? {16'h0000, count_lo} :
                                 hit_cnt_hi ? {16'h0000, count_hi} :
                                 hit_status ? status_word : 32'h0000_0000;

  // control register writes
  // everything is off after reset: no timer runs until software sets the on bit
  // a write to the even word while paired reconfigures both halves at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_lo <= '0;
      ctrl_hi <= '0;
    end else if (wr_en && hit_ctrl_lo) begin
      ctrl_lo <= ctrl_from(pwdata, 1'b1);
    end else if (wr_en && hit_ctrl_hi) begin
      ctrl_hi <= ctrl_from(pwdata, 1'b0);
    end
  end

  // even timer: prescaler and count; a software write wins over a step
  // the prescaler restarts while off, so the first step after on takes a full ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_lo <= presc_reset;
      count_lo <= count_reset;
    end else begin
      if (!ctrl_lo.on) presc_lo <= presc_reset;
      else if (take_lo) presc_lo <= presc_done_lo ? presc_reset : presc_lo + 8'h01;
      if (wr_en && hit_cnt_lo) count_lo <= pwdata[15:0];
      else if (step_lo) count_lo <= count_lo + 16'h0001;
    end
  end

  // odd timer: prescaler idle while paired
  // holding it in reset while paired means leaving pair mode starts it clean
  // the odd count write still works while paired, so software can preset the upper half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_hi <= presc_reset;
      count_hi <= count_reset;
    end else begin
      if (!eff_hi.on || pair) presc_hi <= presc_reset;
      else if (take_hi) presc_hi <= presc_done_hi ? presc_reset : presc_hi + 8'h01;
      if (wr_en && hit_cnt_hi) count_hi <= pwdata[15:0];
      else if (step_hi) count_hi <= count_hi + 16'h0001;
    end
  end

  // edge history for the external inputs and registered gate view
  // reset low matches the idle level of the inputs, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_lo <= 1'b0;
      ext_prev_hi <= 1'b0;
      gate_prev_lo <= 1'b0;
      gate_prev_hi <= 1'b0;
    end else begin
      ext_prev_lo <= ext_clk_lo;
      ext_prev_hi <= ext_clk_hi;
      gate_prev_lo <= gate_lo;
      gate_prev_hi <= gate_hi;
    end
  end

  // bus answer: read data latched in setup so access phase completes at once
  // pready follows the setup cycle only, so a master must not stretch the access phase
  // run outputs are registered, one cycle behind the internal state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      run_lo <= 1'b0;
      run_hi <= 1'b0;
    end else begin
      if (rd_en) prdata <= next_rdata;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      run_lo <= active_lo;
      run_hi <= active_hi;
    end
  end

endmodule // type_b_timer_control

// ### bench/timer_ctrl_asserts.sv
// checker: bus timing and control-register properties at the timer block ports
`timescale 1ns/1ns
module timer_ctrl_asserts
  import timer_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_lo
);
  // read of either control word, and the setup phase of a transfer
  wire rd_ctrl = pready && !pwrite && (paddr == ctrl_lo_addr || paddr == ctrl_hi_addr);
  wire setup = psel && !penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (setup |=> pready) else $error("ready missing");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_map_a: assert property (setup && paddr > status_addr |=> pslverr) else $error("no error");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  unused_zero_a: assert property (rd_ctrl |-> (prdata & 32'hFFFF_5F05) == 32'h0)
    else $error("unused bits set");
  gate_hidden_a: assert property (rd_ctrl && prdata[source_bit] |-> !prdata[gate_bit])
    else $error("gate bit visible");
  odd_pair_a: assert property (rd_ctrl && paddr == ctrl_hi_addr |-> !prdata[pair_bit])
    else $error("odd pair bit");
  off_stops_a: assert property (pready && pwrite && paddr == ctrl_lo_addr && !pwdata[on_bit]
    |-> ##[1:3] !run_lo) else $error("still running");
  read_hold_a: assert property (!(setup && !pwrite) |=> $stable(prdata)) else $error("data moved");
  cover property (pslverr);
  cover property (rd_ctrl && prdata[on_bit]);
  cover property (run_lo ##1 !run_lo);
endmodule // timer_ctrl_asserts
bind type_b_timer_control timer_ctrl_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .run_lo);

// ### bench/tb_type_b_timer_control.sv
// testbench: registers, prescale, idle, gating, external source and pairing
`timescale 1ns/1ns
module tb_type_b_timer_control
  import timer_ctrl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_mode = 0;
  logic ext_clk_lo = 0, ext_clk_hi = 0, gate_lo = 0, gate_hi = 0, pready, pslverr, serr, run_lo, run_hi;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  int fails = 0, check_count = 0;
  always #25 pclk = ~pclk;
  // device under test; every input is driven by the scenarios below
  type_b_timer_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .idle_mode, .ext_clk_lo, .ext_clk_hi, .gate_lo, .gate_hi, .run_lo, .run_hi);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one transfer, then an idle cycle so psel is never assigned twice in a step
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // run the even timer for w idle cycles, stop it, and bound its count
  task automatic cnt(string n, logic [31:0] c, int w, int lo, int hi);
    apb(1, count_lo_addr, 32'h0);
    apb(1, ctrl_lo_addr, c);
    repeat (w) @(posedge pclk);
    apb(1, ctrl_lo_addr, 32'h0); // the task's idle cycle keeps the next access off
    apb(0, count_lo_addr, 32'h0);
    check_count++;
    if ($isunknown(rdat) || rdat < lo || rdat > hi) begin
      fails++;
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, rdat);
    end
  endtask
  task automatic t_regs();
    apb(0, ctrl_lo_addr, 32'h0);
    chk("ctrl reset", ctrl_reset, rdat);
    apb(1, ctrl_lo_addr, 32'hFFFF_FFFF);
    apb(0, ctrl_lo_addr, 32'h0);
    chk("ctrl even", 32'h0000_A07A, rdat);
    apb(1, ctrl_hi_addr, 32'hFFFF_FFFF);
    apb(0, ctrl_hi_addr, 32'h0);
    chk("ctrl odd", 32'h0000_A072, rdat);
    apb(1, ctrl_lo_addr, 32'h0000_A0F8);
    apb(0, ctrl_lo_addr, 32'h0);
    chk("ctrl gate", 32'h0000_A0F8, rdat);
    apb(0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {rdat[31:1], serr});
    apb(1, ctrl_lo_addr, 32'h0);
    apb(1, ctrl_hi_addr, 32'h0);
    $display("regs done");
  endtask
  task automatic t_presc();
    for (int k = 0; k < 8; k++)
      cnt("prescale", 32'h8000 | (k << prescale_lsb), 8 * (k == 7 ? 256 : 1 << k) - 3, 7, 9);
    $display("prescale done");
  endtask
  task automatic t_idle();
    idle_mode <= 1;
    cnt("idle halt", 32'h0000_A000, 20, 0, 0);
    cnt("idle run", 32'h0000_8000, 20, 22, 24);
    idle_mode <= 0;
    $display("idle done");
  endtask
  task automatic t_gate();
    cnt("gate low", 32'h0000_8080, 20, 0, 0);
    gate_lo <= 1;
    cnt("gate high", 32'h0000_8080, 20, 22, 24);
    gate_lo <= 0;
    $display("gate done");
  endtask
  // external source with the gate low: five edges, gate bit ignored
  task automatic t_ext();
    apb(1, count_lo_addr, 32'h0);
    apb(1, ctrl_lo_addr, 32'h0000_8082);
    repeat (10) begin
      repeat (2) @(posedge pclk);
      ext_clk_lo <= ~ext_clk_lo;
    end
    apb(1, ctrl_lo_addr, 32'h0);
    apb(0, count_lo_addr, 32'h0);
    chk("ext count", 32'h5, rdat);
    $display("ext done");
  endtask
  // odd word set off with slow prescale; even wrap must still carry
  task automatic t_pair();
    apb(1, count_hi_addr, 32'h0);
    apb(1, count_lo_addr, 32'h0000_FFFF);
    apb(1, ctrl_hi_addr, 32'h0000_0070);
    apb(1, ctrl_lo_addr, 32'h0000_8008);
    apb(1, ctrl_lo_addr, 32'h0);
    apb(0, count_hi_addr, 32'h0);
    chk("pair carry", 32'h1, rdat);
    $display("pair done");
  endtask
  // odd timer alone (gated, status, run outputs, external edges), then the pair in idle
  task automatic t_odd();
    apb(1, count_hi_addr, 32'h0);
    apb(1, ctrl_hi_addr, 32'h0000_8080);
    gate_hi <= 1;
    repeat (20) @(posedge pclk);
    apb(0, status_addr, 32'h0);
    chk("status", 32'hA, rdat);
    chk("run odd only", 32'h2, {30'h0, run_hi, run_lo});
    apb(1, ctrl_hi_addr, 32'h0);
    gate_hi <= 0;
    apb(0, count_hi_addr, 32'h0);
    chk("odd gate count", 32'h19, rdat);
    apb(1, count_hi_addr, 32'h0);
    apb(1, ctrl_hi_addr, 32'h0000_8082);
    repeat (6) begin
      repeat (2) @(posedge pclk);
      ext_clk_hi <= ~ext_clk_hi;
    end
    apb(1, ctrl_hi_addr, 32'h0);
    apb(0, count_hi_addr, 32'h0);
    chk("odd ext count", 32'h3, rdat);
    idle_mode <= 1;
    apb(1, count_hi_addr, 32'h0);
    apb(1, count_lo_addr, 32'h0000_FFFF);
    apb(1, ctrl_lo_addr, 32'h0000_8008); // odd idle bit left clear
    @(posedge pclk);
    chk("pair idle run", 32'h3, {30'h0, run_hi, run_lo});
    apb(1, ctrl_lo_addr, 32'h0);
    apb(0, count_hi_addr, 32'h0);
    chk("pair idle carry", 32'h1, rdat);
    apb(1, count_hi_addr, 32'h0);
    apb(1, count_lo_addr, 32'h0000_FFFF);
    apb(1, ctrl_hi_addr, 32'h0000_2000);
    apb(1, ctrl_lo_addr, 32'h0000_8008);
    @(posedge pclk);
    chk("pair idle halt", 32'h0, {30'h0, run_hi, run_lo});
    apb(1, ctrl_lo_addr, 32'h0);
    apb(0, count_hi_addr, 32'h0);
    chk("pair halt count", 32'h0, rdat);
    apb(1, ctrl_hi_addr, 32'h0);
    idle_mode <= 0;
    $display("odd done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_presc();
    t_idle();
    t_gate();
    t_ext();
    t_pair();
    t_odd();
    end_sim();
  end
endmodule // tb_type_b_timer_control
